/* hdl/delay_timer.sv */
// small down-counting timer that pulses when a loaded count runs out
`default_nettype none
module delay_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // load control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // status
  output logic o_busy,
  output logic o_done
);
  // timer state
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_t;

  tmr_t q;
  tmr_t next_q;

  // next value: load, count down, pulse done on the last cycle
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (i_load) begin
      next_q.cnt = i_count;
      next_q.busy = (i_count != '0);
      next_q.done = (i_count == '0);
    end else if (q.busy) begin
      // reaching one means the count is spent this edge
      if (q.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
        next_q.cnt = '0;
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end else begin
        next_q.cnt = q.cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // register the state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_busy = q.busy;
  assign o_done = q.done;
endmodule
`default_nettype wire

/* hdl/gate_ctrl_pkg.sv */
// package: constants, types and timing for the three-level gate control
`default_nettype none
package gate_ctrl_pkg;
  // clock rate in MHz (200 MHz, 5 ns period)
  localparam int CLK_MHZ = 200;
  // debounce interval after mid-level entry, in ns
  localparam int DEBOUNCE_NS = 80;
  // debounce in cycles, rounded up, at least one
  localparam int DEBOUNCE_CYC_RAW = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_CYC_RAW < 1) ? 1 : DEBOUNCE_CYC_RAW;
  // default zero-current blanking time, in cycles (plain default)
  localparam int BLANK_CYC_DEF = 20;
  // default non-overlap delay between gates, in cycles (plain default)
  localparam int NOL_CYC_DEF = 4;
  // counter width
  localparam int CNT_W = 16;
  // reset values of gate commands
  localparam logic GATE_RST = 1'b0;

  // one-hot three-level input, resolved by the analog front end
  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } level3_t;

  // gate command pair
  typedef struct packed {
    logic high_side_gate_cmd;
    logic low_side_gate_cmd;
  } gate_cmd_t;

  // controller states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_NOL_TO_HS,
    ST_HS_ON,
    ST_NOL_TO_LS,
    ST_LS_ON,
    ST_ZCD_WAIT,
    ST_ZCD_WATCH
  } ctrl_state_t;
endpackage
`default_nettype wire

/* hdl/tristate_pwm_gate_control.sv */
// top: decodes three-level pulse input and skip select into gate commands
`default_nettype none
// Summary of operation
// R1: skip high, mid entry: high off, low on
// R2: low gate held through debounce and blanking
// R3: then low off when switch node rises
// R4: unconnected skip select reads as high
// R5: controller without detection keeps skip high
// R6: controller toggles high/low; mid enters discontinuous
// R7: controller with own detection drives skip low
// R8: controller drives mid at zero current
// R9: skip low, mid: both gates off at once
// R10: gate turn-ons pass through non-overlap delay
// R11: debounce lasts 80 ns plus blanking
// R12: early zero-current ignored, off at timer end
// R13: one-hot inputs; never both gates on
module tristate_pwm_gate_control
  import gate_ctrl_pkg::*;
#(
  parameter int BLANK_CYC = BLANK_CYC_DEF,
  parameter int NOL_CYC = NOL_CYC_DEF
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // resolved three-level pulse-width input
  input wire gate_ctrl_pkg::level3_t i_pwm_level,
  // resolved skip-mode select; all-zero means unconnected
  input wire gate_ctrl_pkg::level3_t i_skip_mode_select,
  // switch node above zero-current threshold
  input wire logic i_switch_node_sense,
  // gate commands
  output gate_ctrl_pkg::gate_cmd_t o_gate,
  // status
  output logic o_discontinuous_conduction
);
  import gate_ctrl_pkg::*;

  // whole module state
  typedef struct packed {
    ctrl_state_t st;
    gate_cmd_t gate;
    logic discontinuous_conduction;
  } ctl_t;

  ctl_t q;
  ctl_t next_q;

  // skip high or mid both mean device-side detection; unconnected too
  logic skip_dev_zcd;
  // pulse input decoded, high over mid over low
  logic pwm_hi;
  logic pwm_mid;
  logic pwm_lo;
  // timer controls
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;

  // decode inputs; anything not skip-low counts as device detection
  always_comb begin
    skip_dev_zcd = ~i_skip_mode_select.lo; // R4
    pwm_hi = i_pwm_level.hi; // R13
    pwm_mid = i_pwm_level.mid & ~i_pwm_level.hi;
    pwm_lo = i_pwm_level.lo & ~i_pwm_level.hi & ~i_pwm_level.mid;
  end

  // shared timer: non-overlap delay or debounce plus blanking
  delay_timer #(
    .W(CNT_W)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // next-state logic for the gate sequencer
  always_comb begin
    next_q = q;
    tmr_load = 1'b0;
    tmr_count = CNT_W'(NOL_CYC);
    case (q.st)
      // both off: wait for a level that turns a gate on
      ST_OFF: begin
        next_q.gate = '0;
        if (pwm_hi) begin
          next_q.st = ST_NOL_TO_HS; // R10
          tmr_load = 1'b1;
        end else if (pwm_lo || (pwm_mid && skip_dev_zcd && !q.discontinuous_conduction)) begin
          next_q.st = ST_NOL_TO_LS;
          next_q.discontinuous_conduction = pwm_mid;
          tmr_load = 1'b1;
        end
      end
      // high side off, waiting out non-overlap before high turns on
      ST_NOL_TO_HS: begin
        next_q.gate = '0;
        if (!pwm_hi) begin
          next_q.st = ST_OFF;
        end else if (tmr_done) begin
          next_q.st = ST_HS_ON; // R10
          next_q.gate.high_side_gate_cmd = 1'b1;
          next_q.discontinuous_conduction = 1'b0;
        end
      end
      // high side conducting
      ST_HS_ON: begin
        if (!pwm_hi) begin
          // drop high side first, then low after non-overlap, except mid with skip low
          next_q.gate = '0; // R1
          if (pwm_mid && !skip_dev_zcd) begin
            next_q.st = ST_OFF; // R9
          end else begin
            next_q.st = ST_NOL_TO_LS;
            next_q.discontinuous_conduction = pwm_mid;
            tmr_load = 1'b1;
          end
        end
      end
      // both off, then low side on
      ST_NOL_TO_LS: begin
        next_q.gate = '0;
        if (pwm_hi || (pwm_mid && !skip_dev_zcd)) begin
          next_q.st = ST_OFF; // R9
        end else if (tmr_done) begin
          next_q.gate.low_side_gate_cmd = 1'b1; // R1
          if (q.discontinuous_conduction && pwm_mid) begin
            // hold low side for debounce plus blanking
            next_q.st = ST_ZCD_WAIT; // R2
            tmr_load = 1'b1;
            tmr_count = CNT_W'(DEBOUNCE_CYC + BLANK_CYC); // R11
          end else begin
            next_q.st = ST_LS_ON;
            next_q.discontinuous_conduction = 1'b0;
          end
        end
      end
      // low side conducting in continuous mode
      ST_LS_ON: begin
        if (pwm_hi) begin
          next_q.gate = '0; // R10
          next_q.st = ST_NOL_TO_HS;
          tmr_load = 1'b1;
        end else if (pwm_mid) begin
          if (!skip_dev_zcd) begin
            next_q.gate = '0; // R9
            next_q.st = ST_OFF;
          end else begin
            // mid entry with low already on: start detection wait
            next_q.discontinuous_conduction = 1'b1; // R1
            next_q.st = ST_ZCD_WAIT; // R2
            tmr_load = 1'b1;
            tmr_count = CNT_W'(DEBOUNCE_CYC + BLANK_CYC); // R11
          end
        end
      end
      // low side held; zero-current sense ignored until the timer ends
      ST_ZCD_WAIT: begin
        if (pwm_hi) begin
          next_q.gate = '0;
          next_q.st = ST_NOL_TO_HS;
          next_q.discontinuous_conduction = 1'b0;
          tmr_load = 1'b1;
        end else if (pwm_lo) begin
          next_q.st = ST_LS_ON;
          next_q.discontinuous_conduction = 1'b0;
        end else if (!skip_dev_zcd) begin
          next_q.gate = '0; // R9
          next_q.st = ST_OFF;
        end else if (tmr_done) begin
          if (i_switch_node_sense) begin
            // early indication was ignored; off at timer end
            next_q.gate = '0; // R12
            next_q.st = ST_OFF;
          end else begin
            next_q.st = ST_ZCD_WATCH; // R3
          end
        end
      end
      // monitor switch node for zero current
      ST_ZCD_WATCH: begin
        if (pwm_hi) begin
          next_q.gate = '0;
          next_q.st = ST_NOL_TO_HS;
          next_q.discontinuous_conduction = 1'b0;
          tmr_load = 1'b1;
        end else if (pwm_lo) begin
          next_q.st = ST_LS_ON;
          next_q.discontinuous_conduction = 1'b0;
        end else if (i_switch_node_sense || !skip_dev_zcd) begin
          next_q.gate = '0; // R3
          next_q.st = ST_OFF;
        end
      end
      default: begin
        next_q.st = ST_OFF;
        next_q.gate = '0;
        next_q.discontinuous_conduction = 1'b0;
      end
    endcase
    // low level always clears discontinuous latch from the off state
    if (q.st == ST_OFF && pwm_lo) begin
      next_q.discontinuous_conduction = 1'b0;
    end
    // never both gates on
    if (next_q.gate.high_side_gate_cmd) begin
      next_q.gate.low_side_gate_cmd = 1'b0; // R13
    end
  end

  // register the state
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q.st <= ST_OFF;
      q.gate <= {GATE_RST, GATE_RST};
      q.discontinuous_conduction <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from flip-flops
  assign o_gate = q.gate;
  assign o_discontinuous_conduction = q.discontinuous_conduction;

  // busy is only informative inside the timer
  logic unused_busy;
  assign unused_busy = tmr_busy;
endmodule
`default_nettype wire

/* tb/buck_ctrl_model.sv */
// controller model: turns level codes into one-hot three-level inputs
`default_nettype none
module buck_ctrl_model
  import gate_ctrl_pkg::*;
(
  // wanted levels: 0 low, 1 mid, 2 high, 3 open or undriven
  input wire logic [1:0] i_pwm_code,
  input wire logic [1:0] i_skip_code,
  // resolved levels toward the device
  output gate_ctrl_pkg::level3_t o_pwm,
  output gate_ctrl_pkg::level3_t o_skip
);
  // pulse level: high and low switch, mid asks for dcm or zero current
  assign o_pwm = level3_t'({i_pwm_code == 2'h2, i_pwm_code == 2'h1,
    i_pwm_code == 2'h0});
  // skip select: low for own detection, open leaves all zero
  assign o_skip = level3_t'({i_skip_code == 2'h2, i_skip_code == 2'h1,
    i_skip_code == 2'h0});
endmodule
`default_nettype wire

/* tb/gate_ctrl_chk.sv */
// checker: timing relations of the gate control at its ports
`default_nettype none
module gate_ctrl_chk
  import gate_ctrl_pkg::*;
#(
  parameter int BLANK_CYC = BLANK_CYC_DEF,
  parameter int NOL_CYC = NOL_CYC_DEF
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // watched ports
  input wire gate_ctrl_pkg::level3_t i_pwm_level,
  input wire gate_ctrl_pkg::level3_t i_skip_mode_select,
  input wire logic i_switch_node_sense,
  input wire gate_ctrl_pkg::gate_cmd_t o_gate,
  input wire logic o_discontinuous_conduction
);
  localparam int WAIT = DEBOUNCE_CYC + BLANK_CYC;
  logic hs, ls, discontinuous_conduction, mid, skl;
  int held; // ticks the low gate has been on in a dcm sequence
  assign hs = o_gate.high_side_gate_cmd;
  assign ls = o_gate.low_side_gate_cmd;
  assign discontinuous_conduction = o_discontinuous_conduction;
  assign mid = i_pwm_level == 3'h2;
  assign skl = i_skip_mode_select.lo;
  // count consecutive ticks of low gate on with dcm set
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) held <= 0;
    else held <= (ls && discontinuous_conduction) ? held + 1 : 0;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  no_overlap_a: assert property (!(hs && ls))
    else $error("both gates on");
  skip_low_mid_a: assert property (skl && mid |=> !hs && !ls)
    else $error("gates not off at mid with skip low");
  mid_entry_a: assert property (!skl && mid && hs |=> !hs && discontinuous_conduction)
    else $error("mid entry did not drop high gate");
  hi_input_a: assert property (i_pwm_level.hi |=> !ls)
    else $error("low gate on with high input");
  lo_input_a: assert property (i_pwm_level == 3'h1 |=> !hs)
    else $error("high gate on with low input");
  hs_nol_a: assert property ($rose(hs) |->
    !$past(ls) && !$past(ls, NOL_CYC))
    else $error("high gate rose without gap");
  ls_nol_a: assert property ($rose(ls) |->
    !$past(hs) && !$past(hs, NOL_CYC))
    else $error("low gate rose without gap");
  wait_hold_a: assert property ($fell(ls) && $past(discontinuous_conduction) &&
    $past(mid) && !$past(skl) |-> $past(held) >= WAIT - 1)
    else $error("low gate dropped before wait end");
  zcd_off_a: assert property (held > WAIT + 1 &&
    i_switch_node_sense && mid |=> !ls)
    else $error("low gate kept on at zero current");
  cover property (mid && !skl && hs);
  cover property ($fell(ls) && discontinuous_conduction);
  cover property (skl && mid && ls);
endmodule
bind tristate_pwm_gate_control gate_ctrl_chk #(
  .BLANK_CYC(BLANK_CYC),
  .NOL_CYC(NOL_CYC)
) chk_u (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_pwm_level(i_pwm_level),
  .i_skip_mode_select(i_skip_mode_select),
  .i_switch_node_sense(i_switch_node_sense),
  .o_gate(o_gate),
  .o_discontinuous_conduction(o_discontinuous_conduction)
);
`default_nettype wire

/* tb/testbench.sv */
// bench: drives the controller model, queues expected gate states
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gate_ctrl_pkg::*;
  logic i_sys_clk = 0, i_rst = 1, sense = 0;
  logic [1:0] pwm = 2'h3, skip = 2'h2; // no pulse level and skip high until reset ends
  level3_t pwm_lv, skip_lv;
  gate_cmd_t gate;
  logic discontinuous_conduction;
  logic [2:0] q[$]; // expected {high, low, dcm} after each change
  logic [2:0] last = 3'h0;
  int errors = 0, n_tests = 0, cyc = 0, seed = 57;
  // 200 MHz clock
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  buck_ctrl_model ctl_u (.i_pwm_code(pwm), .i_skip_code(skip),
    .o_pwm(pwm_lv), .o_skip(skip_lv));
  tristate_pwm_gate_control #(.BLANK_CYC(12)) dut_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pwm_level(pwm_lv),
    .i_skip_mode_select(skip_lv), .i_switch_node_sense(sense),
    .o_gate(gate), .o_discontinuous_conduction(discontinuous_conduction));
  // prints the counts and the verdict, then stops
  task automatic test_done;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // sets levels at a falling edge, notes the expected changes
  task automatic step(input int p, s, n, input logic [2:0] e1,
      input logic [2:0] e2 = 3'h7);
    @(negedge i_sys_clk);
    pwm = 2'(p);
    skip = 2'(s);
    q.push_back(e1);
    if (e2 != 3'h7) q.push_back(e2);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // takes the oldest note whenever the outputs change; hang limit
  always @(negedge i_sys_clk) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      test_done();
    end else if (!i_rst && {gate, discontinuous_conduction} !== last) begin
      last = {gate, discontinuous_conduction};
      if (q.size() == 0) `CHK(last, 3'h7)
      else `CHK(last, q.pop_front())
    end
  end
  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_rst = 0;
    // continuous switching, skip high
    step(2, 2, 12, 3'h4);
    step(0, 2, 12, 3'h0, 3'h2);
    step(2, 2, 12, 3'h0, 3'h4);
    // mid entry, skip open, noise early in the wait
    step(1, 3, 0, 3'h1, 3'h3);
    q.push_back(3'h1);
    for (int i = 0; i < 45; i++) begin
      @(negedge i_sys_clk);
      sense = (i < 25) ? 1'($random(seed)) : 1'b0;
    end
    sense = 1;
    repeat (5) @(negedge i_sys_clk);
    step(0, 2, 12, 3'h0, 3'h2);
    // mid from low on, skip mid, sense already high
    step(1, 1, 45, 3'h3, 3'h1);
    // gates already off; the dcm flag stays set and clears when high turns on
    step(2, 2, 12, 3'h4);
    // skip low: mid turns both gates off at once
    sense = 0;
    step(1, 0, 12, 3'h0);
    step(0, 0, 12, 3'h2);
    step(1, 0, 12, 3'h0);
    `CHK(q.size(), 0)
    test_done();
  end
endmodule
`default_nettype wire
